// ### src/csc_top.sv
// Channel B status and control: loss pin, lane rotation jog, power-down,
// reference clock choice, behind an AXI4-Lite register port.
// Assumes all pin inputs are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Loss pin high on lost signal, low when valid signal seen.
// - In the loss function, loss reported only while detection is enabled.
// - Loss pin may carry other live status, chosen by a register field.
// - During device reset the loss pin is driven low.
// - Loss pin floats during pin or register power-down.
// - Each jog pin edge, either way, rotates lane order by one.
// - Power-down pin low keeps channel B down; high runs normally.
// - Each channel's reference clock picked by registers or select pins.
// - In pin mode, shared select high forces clock one; low leaves each channel's own select pin to choose.
module csc_top #(
  parameter int LANES = 8,
  parameter int ROT_W = $clog2(LANES)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and analog status
  input wire logic level_low_b,
  input wire logic lane_rotate_jog_b,
  input wire logic channel_b_powerdown_low,
  input wire logic shared_clock_choice,
  input wire logic chan_a_clock_choice,
  input wire logic chan_b_clock_choice,
  output logic loss_of_signal_b_o,
  output logic loss_of_signal_b_oe,
  output logic spare_output_b,
  output logic [ROT_W-1:0] lane_rotation_b,
  output logic chan_b_power_down,
  output logic chan_a_ref_one,
  output logic chan_b_ref_one,
  output logic datapath_reset_b
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  csc_sync_if #(.W(csc_pkg::SYNC_W)) sync_bus ();
  assign sync_bus.raw = {chan_b_clock_choice, chan_a_clock_choice, shared_clock_choice,
                         channel_b_powerdown_low, lane_rotate_jog_b, level_low_b};

  csc_sync_bank #(.W(csc_pkg::SYNC_W), .RESET_VAL(csc_pkg::SYNC_RESET)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sig(sync_bus)
  );

  logic level_s;
  logic jog_s;
  logic pd_low_s;
  logic shared_s;
  logic chan_a_s;
  logic chan_b_s;
  assign level_s = sync_bus.synced[csc_pkg::SYN_LEVEL];
  assign jog_s = sync_bus.synced[csc_pkg::SYN_JOG];
  assign pd_low_s = sync_bus.synced[csc_pkg::SYN_PD_LOW];
  assign shared_s = sync_bus.synced[csc_pkg::SYN_SHARED];
  assign chan_a_s = sync_bus.synced[csc_pkg::SYN_CHAN_A];
  assign chan_b_s = sync_bus.synced[csc_pkg::SYN_CHAN_B];

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0] ctrl;
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] status_word;
  logic wr_fire;

  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  // Write channels taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= csc_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == csc_pkg::ADDR_CTRL) ? csc_pkg::RESP_OKAY
                                                       : csc_pkg::RESP_SLVERR;
      end
      // Ready again only once the response is taken: one write in flight
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register; datapath reset bit self-clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= csc_pkg::CTRL_RESET;
      datapath_reset_b <= 1'b0;
    end else if (ce) begin
      datapath_reset_b <= 1'b0;
      if (wr_fire && aw_addr == csc_pkg::ADDR_CTRL && w_strb[0]) begin
        ctrl <= w_data[7:0] & ~(8'h01 << csc_pkg::CTRL_DP_RESET);
        datapath_reset_b <= w_data[csc_pkg::CTRL_DP_RESET];
      end
    end
  end

  // Status word gathers live block state
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[csc_pkg::STAT_LEVEL] = level_s;
    status_word[csc_pkg::STAT_PD] = chan_b_power_down;
    status_word[csc_pkg::STAT_SEL_A] = chan_a_ref_one;
    status_word[csc_pkg::STAT_SEL_B] = chan_b_ref_one;
    status_word[csc_pkg::STAT_ROT_LO +: ROT_W] = lane_rotation_b;
  end

  // Read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= csc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr)
          csc_pkg::ADDR_CTRL: begin
            s_axi_rdata <= {24'h00_0000, ctrl};
            s_axi_rresp <= csc_pkg::RESP_OKAY;
          end
          csc_pkg::ADDR_STATUS: begin
            s_axi_rdata <= status_word;
            s_axi_rresp <= csc_pkg::RESP_OKAY;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= csc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Power-down and clock choice
  // ****************************************
  logic next_pd;
  assign next_pd = !pd_low_s || ctrl[csc_pkg::CTRL_REG_PD];

  // Pin mode: shared select forces clock one, else per-channel pin decides
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_b_power_down <= 1'b0;
      chan_a_ref_one <= 1'b0;
      chan_b_ref_one <= 1'b0;
    end else if (ce) begin
      chan_b_power_down <= next_pd;
      if (ctrl[csc_pkg::CTRL_SW_CLK]) begin
        chan_a_ref_one <= ctrl[csc_pkg::CTRL_SEL_A];
        chan_b_ref_one <= ctrl[csc_pkg::CTRL_SEL_B];
      end else begin
        chan_a_ref_one <= shared_s || chan_a_s;
        chan_b_ref_one <= shared_s || chan_b_s;
      end
    end
  end

  // ****************************************
  // Lane rotation jog
  // ****************************************
  logic jog_prev;
  logic [1:0] jog_arm;
  logic jog_edge;
  // Edges ignored until the synchroniser holds the real pin level, so a
  // pin already high at reset release is not taken as a transition
  assign jog_edge = (jog_arm == csc_pkg::JOG_ARM_DONE) && (jog_s != jog_prev);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jog_prev <= 1'b0;
      jog_arm <= 2'h0;
      lane_rotation_b <= '0;
    end else if (ce) begin
      jog_prev <= jog_s;
      if (jog_arm != csc_pkg::JOG_ARM_DONE) begin
        jog_arm <= jog_arm + 2'h1;
      end
      if (jog_edge) begin
        lane_rotation_b <= ROT_W'(lane_rotation_b + 1'b1);
      end
    end
  end

  // ****************************************
  // Loss pin
  // ****************************************
  logic next_loss;
  always_comb begin
    case (ctrl[csc_pkg::CTRL_FSEL_HI:csc_pkg::CTRL_FSEL_LO])
      csc_pkg::FSEL_LOSS: next_loss = level_s && ctrl[csc_pkg::CTRL_DET_EN];
      csc_pkg::FSEL_ROT_LSB: next_loss = lane_rotation_b[0];
      csc_pkg::FSEL_RAW_LEVEL: next_loss = level_s;
      csc_pkg::FSEL_CLK_B: next_loss = chan_b_ref_one;
      default: next_loss = 1'b0;
    endcase
  end

  // Reset drives low; power-down releases the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_of_signal_b_o <= 1'b0;
      loss_of_signal_b_oe <= 1'b1;
    end else if (ce) begin
      loss_of_signal_b_o <= next_pd ? 1'b0 : next_loss;
      loss_of_signal_b_oe <= !next_pd;
    end
  end

  // Spare output unused, held low
  always_ff @(posedge aclk) begin
    spare_output_b <= 1'b0;
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_loss_reset: assert property (@(posedge aclk) !aresetn |=>
    (!loss_of_signal_b_o && loss_of_signal_b_oe))
    else $error("loss pin not driven low in reset");

  chk_pd_float: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && next_pd) |=> !loss_of_signal_b_oe)
    else $error("loss pin driven during power-down");

  chk_jog_rotate: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && jog_edge) |=> lane_rotation_b == ROT_W'($past(lane_rotation_b) + 1'b1))
    else $error("jog edge did not rotate by one");

  chk_loss_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !ctrl[csc_pkg::CTRL_DET_EN] && ctrl[2:1] == csc_pkg::FSEL_LOSS) |=>
    !loss_of_signal_b_o)
    else $error("loss reported while detection disabled");

  chk_loss_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ctrl[csc_pkg::CTRL_DET_EN] && ctrl[2:1] == csc_pkg::FSEL_LOSS && !next_pd)
    |=> loss_of_signal_b_o == $past(level_s))
    else $error("loss pin does not follow level detect");

  chk_raw_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ctrl[2:1] == csc_pkg::FSEL_RAW_LEVEL && !next_pd) |=>
    loss_of_signal_b_o == $past(level_s))
    else $error("alternate loss pin function wrong");

  chk_pd_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !pd_low_s) |=> (chan_b_power_down && !loss_of_signal_b_oe))
    else $error("power-down pin not obeyed");

  chk_clk_shared: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !ctrl[csc_pkg::CTRL_SW_CLK] && shared_s) |=> (chan_a_ref_one && chan_b_ref_one))
    else $error("shared select did not pick clock one");

  chk_clk_sw: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ctrl[csc_pkg::CTRL_SW_CLK]) |=>
    chan_b_ref_one == $past(ctrl[csc_pkg::CTRL_SEL_B]))
    else $error("register clock select ignored");

  chk_ce_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    !ce |=> ($stable(lane_rotation_b) && $stable(ctrl) && $stable(chan_b_power_down)))
    else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// ### pkg/csc_pkg.sv
// Shared constants for the channel B status and control block.
// Assumes a 10 MHz aclk and a 32-bit AXI4-Lite register port.
package csc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_HOLD_NS = 10000; // Least device reset hold time
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // Control register fields
  localparam int CTRL_DET_EN = 0;
  localparam int CTRL_FSEL_LO = 1;
  localparam int CTRL_FSEL_HI = 2;
  localparam int CTRL_REG_PD = 3;
  localparam int CTRL_SW_CLK = 4;
  localparam int CTRL_SEL_A = 5;
  localparam int CTRL_SEL_B = 6;
  localparam int CTRL_DP_RESET = 7;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // Status register fields
  localparam int STAT_LEVEL = 0;
  localparam int STAT_PD = 1;
  localparam int STAT_SEL_A = 2;
  localparam int STAT_SEL_B = 3;
  localparam int STAT_ROT_LO = 8;

  // Functions routed onto the loss pin
  localparam logic [1:0] FSEL_LOSS = 2'h0;
  localparam logic [1:0] FSEL_ROT_LSB = 2'h1;
  localparam logic [1:0] FSEL_RAW_LEVEL = 2'h2;
  localparam logic [1:0] FSEL_CLK_B = 2'h3;

  // ****************************************
  // Synchroniser bank bit positions
  // ****************************************
  localparam int SYNC_W = 6;
  localparam int SYN_LEVEL = 0;
  localparam int SYN_JOG = 1;
  localparam int SYN_PD_LOW = 2;
  localparam int SYN_SHARED = 3;
  localparam int SYN_CHAN_A = 4;
  localparam int SYN_CHAN_B = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h04; // Power-down pin idles high
  // Enabled edges after reset before jog edges count; covers the two sync flops
  localparam logic [1:0] JOG_ARM_DONE = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### pkg/csc_sync_if.sv
// Carrier between the control block and its input synchroniser bank.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps
`default_nettype none
interface csc_sync_if #(
  parameter int W = 6
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport ctl (output raw, input synced);
  modport bank (input raw, output synced);
endinterface
`default_nettype wire

// ### src/csc_sync_bank.sv
// Two-flop synchroniser bank for asynchronous pins.
// Assumes raw inputs come from pins outside the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module csc_sync_bank #(
  parameter int W = 6,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  csc_sync_if.bank sig
);

  // ****************************************
  // Per-bit synchroniser
  // ****************************************
  logic [W-1:0] meta;
  logic [W-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // First flop feeds only the second flop
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta[i] <= RESET_VAL[i];
          stage2[i] <= RESET_VAL[i];
        end else if (ce) begin
          meta[i] <= sig.raw[i];
          stage2[i] <= meta[i];
        end
      end
    end
  endgenerate

  assign sig.synced = stage2;

endmodule
`default_nettype wire

// ### sim/csc_board_pins.sv
// Board controller model: drives the channel B control pins.
// Assumes the bench calls its tasks just after a rising aclk edge.
`timescale 1ns/1ps
`default_nettype none
module csc_board_pins (
  input wire logic aclk,
  output var logic level_low_b,
  output var logic jog,
  output var logic pd_low,
  output var logic shared,
  output var logic chan_a,
  output var logic chan_b
);
  // ****
  // Pin drivers
  // ****
  // Power-down pin idles high so the channel starts running
  initial begin
    {level_low_b, jog, shared, chan_a, chan_b} = 5'h0_0;
    pd_low = 1'b1;
  end

  // Level, power-down and clock choice pins change together
  task automatic apply(input logic [4:0] p);
    @(posedge aclk);
    {level_low_b, pd_low, shared, chan_a, chan_b} <= p;
  endtask

  // Each level is held three edges so the synchroniser sees it
  task automatic toggle_jog();
    @(posedge aclk);
    jog <= ~jog;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### sim/csc_top_tb_top.sv
// Bench for csc_top: AXI4-Lite master, reference model, random pins.
// Assumes csc_board_pins for pin stimulus and a 10 MHz aclk.
`timescale 1ns/1ps
`default_nettype none
module csc_top_tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lvl, jog, pdl, shc, cha, chb;
  logic los_o, los_oe, spare, pwd, ref_a, ref_b, dpr, ce;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, seed, v, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] rot;
  logic [7:0] ctrl, wb;
  int err_count, samples_checked, cycles, pulses, exp_pulses, jogs;

  csc_top u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .level_low_b(lvl),
    .lane_rotate_jog_b(jog),
    .channel_b_powerdown_low(pdl),
    .shared_clock_choice(shc),
    .chan_a_clock_choice(cha),
    .chan_b_clock_choice(chb),
    .loss_of_signal_b_o(los_o),
    .loss_of_signal_b_oe(los_oe),
    .spare_output_b(spare),
    .lane_rotation_b(rot),
    .chan_b_power_down(pwd),
    .chan_a_ref_one(ref_a),
    .chan_b_ref_one(ref_b),
    .datapath_reset_b(dpr)
  );

  csc_board_pins u_pins (
    .aclk(aclk),
    .level_low_b(lvl),
    .jog(jog),
    .pd_low(pdl),
    .shared(shc),
    .chan_a(cha),
    .chan_b(chb)
  );

  // ****
  // Clock, timeout, pulse count
  // ****
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // About 500 cycles are needed; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cycles++;
    if (dpr === 1'b1) pulses++;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end

  // ****
  // Model and compare
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Software select bit overrides the pins; pins OR with shared
  function automatic logic [1:0] refs_exp();
    return ctrl[4] ? {ctrl[6], ctrl[5]} : {shc | chb, shc | cha};
  endfunction

  function automatic logic src_exp();
    logic [1:0] rf;
    rf = refs_exp();
    case (ctrl[2:1])
      2'h0: return lvl & ctrl[0];
      2'h1: return jogs[0];
      2'h2: return lvl;
      default: return rf[1];
    endcase
  endfunction

  task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic check_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    check_val(what, 32'(e), 32'(g));
  endtask

  // ****
  // Bus master
  // ****
  task automatic axi_write(input logic [3:0] a, input logic [31:0] x, input logic [3:0] s);
    bit aw, w;
    aw = 0;
    w = 0;
    // One edge between transfers so bready is never set twice in a step
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Pin outputs, then STATUS and CTRL read back
  task automatic check_pins();
    logic p;
    logic [1:0] rf;
    p = !pdl | ctrl[3];
    rf = refs_exp();
    check_val("power_down", 32'(p), 32'(pwd));
    check_val("loss_oe", 32'(!p), 32'(los_oe));
    check_val("loss_o", 32'(!p & src_exp()), 32'(los_o));
    check_val("rotation", 32'(jogs % 8), 32'(rot));
    check_val("refs", 32'(rf), 32'({ref_b, ref_a}));
    check_val("spare", 32'h0000_0000, 32'(spare));
    axi_read(4'h4);
    check_val("status", {21'h0, 3'(jogs), 4'h0, rf, p, lvl}, d);
    axi_read(4'h0);
    check_val("ctrl", 32'(ctrl), d);
  endtask

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h000_0000_0000;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    pulses = 0;
    exp_pulses = 0;
    jogs = 0;
    ce = 1'b1;
    ctrl = 8'h01;
    seed = 32'h0000_005B;
    repeat (10) @(posedge aclk);
    check_val("loss_o reset", 32'h0000_0000, 32'(los_o));
    check_val("loss_oe reset", 32'h0000_0001, 32'(los_oe));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check_pins();
    // Refused and byte-masked accesses leave CTRL alone
    axi_read(4'h8);
    check_resp("unmapped read", csc_pkg::RESP_SLVERR, r);
    check_val("unmapped rdata", 32'h0000_0000, d);
    axi_write(4'hC, 32'hFFFF_FFFF, 4'hF);
    check_resp("unmapped write", csc_pkg::RESP_SLVERR, r);
    axi_write(4'h4, 32'hFFFF_FFFF, 4'hF);
    check_resp("status write", csc_pkg::RESP_SLVERR, r);
    axi_write(4'h0, 32'h0000_00FE, 4'hE);
    check_resp("masked write", csc_pkg::RESP_OKAY, r);
    check_pins();
    // Random pins, jogs and CTRL; loss pin function walks all four
    for (int i = 0; i < 16; i++) begin
      v = xs();
      u_pins.apply(v[4:0]);
      for (int k = 0; k < int'(v[6:5]); k++) begin
        u_pins.toggle_jog();
        jogs++;
      end
      wb = {v[15:11], 2'(i), v[8]};
      axi_write(4'h0, {v[31:8], wb}, 4'hF);
      check_resp("ctrl write", csc_pkg::RESP_OKAY, r);
      ctrl = wb & 8'h7F;
      exp_pulses += int'(wb[7]);
      repeat (4) @(posedge aclk);
      check_pins();
    end
    check_val("dp pulses", 32'(exp_pulses), 32'(pulses));
    // Clock enable low freezes the block; the jog lands once it returns
    @(posedge aclk);
    ce <= 1'b0;
    u_pins.toggle_jog();
    repeat (4) @(posedge aclk);
    check_val("rotation frozen", 32'(3'(jogs)), 32'(rot));
    ce <= 1'b1;
    jogs++;
    repeat (4) @(posedge aclk);
    check_pins();
    // Mid-run reset with the jog pin high: release must not rotate
    if (jog !== 1'b1) begin
      u_pins.toggle_jog();
      jogs++;
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (csc_pkg::RESET_HOLD_CYCLES) @(posedge aclk);
    check_val("loss_o reset", 32'h0000_0000, 32'(los_o));
    check_val("loss_oe reset", 32'h0000_0001, 32'(los_oe));
    aresetn <= 1'b1;
    ctrl = 8'h01;
    jogs = 0;
    repeat (4) @(posedge aclk);
    check_pins();
    complete_run();
  end
endmodule
`default_nettype wire
